// >>> core/crs_device.sv
// crs_device: processor end of the reset, power and sideband link
// assumes platform keeps power-good and reset sequencing legal
//
// Summary of operation
// - platform holds power-good low, then clean rise
// - power-good may drop; restabilise before rising
// - reset pulse 1 to 10 ms after power-good
// - keep power-good high during boundary scan
// - bus owner drives request command lines
// - reset returns known state, drops caches unwritten
// - power-on reset lasts at least 1 ms
// - agents release bus outputs within two clocks; device takes three
// - reset never held over 10 ms with power-good
// - sample config pins at reset release
// - responding agent drives response status lines
// - responder drives matching response parity
// - idle status reads parity high, correct
// - management interrupt: save, enter mode, acknowledge
// - interrupt during reset release floats outputs
// - clock-halt request: grant state, acknowledge, gate; core clocks gate with grant state, one cycle before the acknowledge
// - grant state still snoops and serves interrupts
// - halt release restarts clocks, resumes execution
// - halt request asynchronous, bus clock unaffected
// - management interrupt may arrive asynchronously
`timescale 1ns/1ps
module crs_device
(
	input wire logic clk,
	crs_link_if.device link,
	output logic mgmt_mode,
	output logic grant_state,
	output logic core_clk_en,
	output logic cache_valid,
	output logic state_saved,
	output logic outputs_float,
	output logic [crs_pkg::CFG_W-1:0] cfg_latched,
	output logic parity_error,
	input wire logic mgmt_exit,
	input wire logic resp_req,
	input wire logic [crs_pkg::RS_W-1:0] resp_code
);
	// ------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------
	logic pg_s;
	logic rst_n_s;
	logic smi_n_s;
	logic halt_n_s;
	crs_sync u_pg (.clk(clk), .reset(1'b0), .async_in(link.supply_ok_in),
		.sync_out(pg_s));
	crs_sync u_rst (.clk(clk), .reset(1'b0), .async_in(link.reset_n),
		.sync_out(rst_n_s));
	crs_sync u_smi (.clk(clk), .reset(1'b0),
		.async_in(link.mgmt_interrupt_n), .sync_out(smi_n_s));
	crs_sync u_halt (.clk(clk), .reset(1'b0),
		.async_in(link.clock_halt_req_n), .sync_out(halt_n_s));

	// ------------------------------------------------------------
	// reset qualification
	// ------------------------------------------------------------
	logic in_reset;
	logic rst_prev_reg;
	logic release_edge;
	assign in_reset = ~pg_s | ~rst_n_s;
	assign release_edge = rst_prev_reg & ~in_reset;
	always_ff @(posedge clk)
	begin
		rst_prev_reg <= in_reset;
	end

	// ------------------------------------------------------------
	// control state
	// ------------------------------------------------------------
	crs_pkg::crs_state_e state_reg;
	crs_pkg::crs_state_e state_next;
	logic mgmt_req;
	logic halt_req;
	logic ack_pending_reg;
	logic [crs_pkg::CMD_W-1:0] ack_cmd_reg;
	assign mgmt_req = ~smi_n_s;
	assign halt_req = ~halt_n_s;

	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			crs_pkg::CRS_RESET:
				if (release_edge)
					state_next = mgmt_req ? crs_pkg::CRS_FLOAT
						: crs_pkg::CRS_RUN;
			crs_pkg::CRS_RUN:
				if (mgmt_req)
					state_next = crs_pkg::CRS_MGMT;
				else if (halt_req)
					state_next = crs_pkg::CRS_GRANT;
			crs_pkg::CRS_GRANT:
				if (mgmt_req)
					state_next = crs_pkg::CRS_MGMT;
				else if (!halt_req)
					state_next = crs_pkg::CRS_RUN;
			crs_pkg::CRS_MGMT:
				if (mgmt_exit)
					state_next = crs_pkg::CRS_RUN;
			crs_pkg::CRS_FLOAT:
				state_next = crs_pkg::CRS_FLOAT;
			default:
				state_next = crs_pkg::CRS_RESET;
		endcase
		if (in_reset)
			state_next = crs_pkg::CRS_RESET;
	end

	always_ff @(posedge clk)
	begin
		state_reg <= state_next;
	end

	// ------------------------------------------------------------
	// acknowledge transactions and core side outputs
	// ------------------------------------------------------------
	logic enter_mgmt;
	logic enter_grant;
	assign enter_mgmt = state_next == crs_pkg::CRS_MGMT
		&& state_reg != crs_pkg::CRS_MGMT;
	assign enter_grant = state_next == crs_pkg::CRS_GRANT
		&& state_reg != crs_pkg::CRS_GRANT;

	always_ff @(posedge clk)
	begin
		if (in_reset)
		begin
			ack_pending_reg <= 1'b0;
			ack_cmd_reg <= crs_pkg::CMD_IDLE;
			mgmt_mode <= 1'b0;
			grant_state <= 1'b0;
			core_clk_en <= 1'b0;
			cache_valid <= 1'b0;
			state_saved <= 1'b0;
			outputs_float <= 1'b0;
		end
		else
		begin
			ack_pending_reg <= enter_mgmt | enter_grant;
			ack_cmd_reg <= enter_mgmt ? crs_pkg::CMD_MGMT_ACK
				: (enter_grant ? crs_pkg::CMD_GRANT_ACK
				: crs_pkg::CMD_IDLE);
			mgmt_mode <= state_next == crs_pkg::CRS_MGMT;
			grant_state <= state_next == crs_pkg::CRS_GRANT;
			// core clocks gated in grant; bus side keeps running
			core_clk_en <= state_next == crs_pkg::CRS_RUN
				|| state_next == crs_pkg::CRS_MGMT;
			cache_valid <= 1'b1;
			if (enter_mgmt)
				state_saved <= 1'b1;
			else if (mgmt_exit)
				state_saved <= 1'b0;
			outputs_float <= state_next == crs_pkg::CRS_FLOAT;
		end
	end

	// ------------------------------------------------------------
	// power-on configuration capture
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!pg_s)
			cfg_latched <= '0;
		else if (release_edge)
			cfg_latched <= link.cfg_pins;
	end

	// ------------------------------------------------------------
	// bus drive: request command and response status
	// ------------------------------------------------------------
	logic bus_allowed;
	// hold off one cycle past release so a float decision is never overrun
	assign bus_allowed = ~in_reset && state_reg != crs_pkg::CRS_FLOAT
		&& state_reg != crs_pkg::CRS_RESET;
	always_ff @(posedge clk)
	begin
		// synchroniser plus this flop releases within three clocks
		if (!bus_allowed)
		begin
			link.dev_req_oe <= 1'b0;
			link.dev_req_cmd_n <= ~crs_pkg::CMD_IDLE;
			link.dev_addr_strobe_n <= 1'b1;
			link.dev_rs_oe <= 1'b0;
			link.dev_rs_n <= 3'h7;
			link.dev_rsp_n <= 1'b1;
		end
		else
		begin
			link.dev_req_oe <= ack_pending_reg;
			link.dev_req_cmd_n <= ~ack_cmd_reg;
			link.dev_addr_strobe_n <= ~ack_pending_reg;
			link.dev_rs_oe <= resp_req;
			link.dev_rs_n <= resp_req ? ~resp_code : 3'h7;
			link.dev_rsp_n <= resp_req ? crs_pkg::crs_parity(~resp_code)
				: 1'b1;
		end
	end

	// ------------------------------------------------------------
	// response parity check on the shared lines
	// ------------------------------------------------------------
	logic rs_idle;
	logic parity_ok;
	assign rs_idle = ~link.response_status_n == crs_pkg::RS_IDLE;
	assign parity_ok = rs_idle ? link.response_parity_n
		: link.response_parity_n
		== crs_pkg::crs_parity(link.response_status_n);
	always_ff @(posedge clk)
	begin
		if (in_reset)
			parity_error <= 1'b0;
		else
			parity_error <= ~parity_ok;
	end
endmodule : crs_device

// >>> core/crs_pkg.sv
// crs_pkg: shared constants for the reset, power and sideband control link
// assumes a single 100 MHz bus clock on both ends
package crs_pkg;
	localparam int unsigned CLK_MHZ = 100;
	localparam int unsigned RESET_MIN_MS = 1;
	localparam int unsigned RESET_MAX_MS = 10;
	localparam int unsigned CYC_PER_MS = CLK_MHZ * 1000;
	// reset pulse length driven by the platform end, in cycles
	localparam int unsigned RESET_MIN_CYC = RESET_MIN_MS * CYC_PER_MS;
	localparam int unsigned RESET_MAX_CYC = RESET_MAX_MS * CYC_PER_MS;
	localparam int unsigned RELEASE_CYC = 2;
	localparam int unsigned CMD_W = 5;
	localparam int unsigned RS_W = 3;
	localparam int unsigned CFG_W = 8;
	localparam logic [RS_W-1:0] RS_IDLE = 3'h0;
	localparam logic [CMD_W-1:0] CMD_IDLE = 5'h00;
	localparam logic [CMD_W-1:0] CMD_MGMT_ACK = 5'h11;
	localparam logic [CMD_W-1:0] CMD_GRANT_ACK = 5'h12;

	typedef enum logic [2:0]
	{
		CRS_OFF = 3'h0,
		CRS_RESET = 3'h1,
		CRS_RUN = 3'h3,
		CRS_GRANT = 3'h2,
		CRS_MGMT = 3'h6,
		CRS_FLOAT = 3'h7
	} crs_state_e;

	// parity: high when an even number of active-low lines are low
	function automatic logic crs_parity(input logic [RS_W-1:0] rs_n);
		crs_parity = ~(^(~rs_n));
	endfunction : crs_parity
endpackage : crs_pkg

// >>> core/crs_link_if.sv
// crs_link_if: sideband and shared bus pins between device and platform
// assumes both ends share clk; shared lines resolved here from enables
`timescale 1ns/1ps
interface crs_link_if;
	logic supply_ok_in;
	logic reset_n;
	logic mgmt_interrupt_n;
	logic clock_halt_req_n;
	logic [crs_pkg::CMD_W-1:0] dev_req_cmd_n;
	logic dev_req_oe;
	logic dev_addr_strobe_n;
	logic [crs_pkg::RS_W-1:0] dev_rs_n;
	logic dev_rsp_n;
	logic dev_rs_oe;
	logic [crs_pkg::RS_W-1:0] plat_rs_n;
	logic plat_rsp_n;
	logic plat_rs_oe;
	logic [crs_pkg::CFG_W-1:0] cfg_pins;
	// wired result of the shared response lines, idle pulled high
	logic [crs_pkg::RS_W-1:0] response_status_n;
	logic response_parity_n;
	assign response_status_n = dev_rs_oe ? dev_rs_n :
		(plat_rs_oe ? plat_rs_n : 3'h7);
	assign response_parity_n = dev_rs_oe ? dev_rsp_n :
		(plat_rs_oe ? plat_rsp_n : 1'b1);

	modport device
	(
		input supply_ok_in, reset_n, mgmt_interrupt_n, clock_halt_req_n,
		input cfg_pins, response_status_n, response_parity_n,
		output dev_req_cmd_n, dev_req_oe, dev_addr_strobe_n,
		output dev_rs_n, dev_rsp_n, dev_rs_oe
	);
	modport platform
	(
		output supply_ok_in, reset_n, mgmt_interrupt_n, clock_halt_req_n,
		output cfg_pins, plat_rs_n, plat_rsp_n, plat_rs_oe,
		input dev_req_cmd_n, dev_req_oe, dev_addr_strobe_n,
		input response_status_n, response_parity_n
	);
endinterface : crs_link_if

// >>> core/crs_sync.sv
// crs_sync: two-flop level synchroniser
// assumes input is asynchronous to clk
`timescale 1ns/1ps
module crs_sync
(
	input wire logic clk,
	input wire logic reset,
	input wire logic async_in,
	output logic sync_out
);
	logic meta_reg;
	logic sync_reg;
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			meta_reg <= 1'b1;
			sync_reg <= 1'b1;
		end
		else
		begin
			meta_reg <= async_in;
			sync_reg <= meta_reg;
		end
	end
	assign sync_out = sync_reg;
endmodule : crs_sync

// >>> core/crs_platform.sv
// crs_platform: platform end, sequences power-good and reset
// assumes supplies_stable is a clean same-clock level
`timescale 1ns/1ps
module crs_platform
#(
	parameter int unsigned RESET_CYC = crs_pkg::RESET_MIN_CYC
)
(
	input wire logic clk,
	input wire logic reset,
	crs_link_if.platform link,
	input wire logic supplies_stable,
	input wire logic mgmt_req,
	input wire logic halt_req,
	input wire logic [crs_pkg::CFG_W-1:0] cfg_value,
	input wire logic resp_req,
	input wire logic [crs_pkg::RS_W-1:0] resp_code,
	output logic sys_running
);
	// ------------------------------------------------------------
	// power-good and reset pulse
	// ------------------------------------------------------------
	logic [23:0] cnt_reg;
	logic pg_reg;
	always_ff @(posedge clk)
	begin
		if (reset || !supplies_stable)
		begin
			pg_reg <= 1'b0;
			cnt_reg <= '0;
			link.reset_n <= 1'b0;
		end
		else
		begin
			pg_reg <= 1'b1;
			if (cnt_reg != 24'(RESET_CYC))
				cnt_reg <= cnt_reg + 24'h000001;
			link.reset_n <= cnt_reg == 24'(RESET_CYC);
		end
	end
	assign link.supply_ok_in = pg_reg;

	// ------------------------------------------------------------
	// sideband requests, configuration, responses
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			link.mgmt_interrupt_n <= 1'b1;
			link.clock_halt_req_n <= 1'b1;
			link.cfg_pins <= '0;
			link.plat_rs_oe <= 1'b0;
			link.plat_rs_n <= 3'h7;
			link.plat_rsp_n <= 1'b1;
			sys_running <= 1'b0;
		end
		else
		begin
			link.mgmt_interrupt_n <= ~mgmt_req;
			link.clock_halt_req_n <= ~halt_req;
			link.cfg_pins <= cfg_value;
			// drop response drive when reset is active
			link.plat_rs_oe <= resp_req & link.reset_n;
			link.plat_rs_n <= resp_req ? ~resp_code : 3'h7;
			link.plat_rsp_n <= resp_req ? crs_pkg::crs_parity(~resp_code)
				: 1'b1;
			sys_running <= link.reset_n;
		end
	end
endmodule : crs_platform

// >>> verification/crs_link_chk.sv
// crs_link_chk: assertions on the link between device and platform
// assumes one clock; platform reset is synchronous, active high
`timescale 1ns/1ps
module crs_link_chk
(
	input wire logic clk,
	input wire logic reset,
	input wire logic supply_ok_in,
	input wire logic reset_n,
	input wire logic mgmt_interrupt_n,
	input wire logic clock_halt_req_n,
	input wire logic [crs_pkg::CMD_W-1:0] dev_req_cmd_n,
	input wire logic dev_req_oe,
	input wire logic dev_addr_strobe_n,
	input wire logic dev_rs_oe,
	input wire logic [crs_pkg::RS_W-1:0] response_status_n,
	input wire logic response_parity_n
);
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	wire bus_off = !dev_req_oe && !dev_rs_oe;
	wire [4:0] mack = ~crs_pkg::CMD_MGMT_ACK;
	wire [4:0] gack = ~crs_pkg::CMD_GRANT_ACK;
	sequence s_halt;
		$fell(clock_halt_req_n) && reset_n && mgmt_interrupt_n;
	endsequence
	sequence s_ack(logic [4:0] c);
		!dev_addr_strobe_n && dev_req_oe && dev_req_cmd_n == c;
	endsequence
	property p_release; $fell(reset_n) |-> ##[0:3] bus_off; endproperty
	property p_held; (!reset_n)[*4] |-> bus_off; endproperty
	property p_parity;
		response_parity_n == ~^(~response_status_n);
	endproperty
	property p_strobe; !dev_addr_strobe_n |=> dev_addr_strobe_n; endproperty
	property p_cmd; !dev_addr_strobe_n |-> s_ack(mack) or s_ack(gack);
	endproperty
	property p_sync; s_halt |-> ##1 dev_addr_strobe_n[*2]; endproperty
	property p_grant; s_halt |-> ##[2:8] s_ack(gack); endproperty
	property p_mgmt;
		$fell(mgmt_interrupt_n) && reset_n |-> ##[2:8] s_ack(mack);
	endproperty
	property p_float;
		$rose(reset_n) && !mgmt_interrupt_n |=> bus_off[*8];
	endproperty
	property p_pg; $rose(supply_ok_in) |-> (!reset_n)[*8]; endproperty
	a_release: assert property (p_release) else $error("bus kept");
	a_held: assert property (p_held) else $error("bus driven");
	a_parity: assert property (p_parity) else $error("parity");
	a_strobe: assert property (p_strobe) else $error("strobe long");
	a_cmd: assert property (p_cmd) else $error("bad command");
	a_sync: assert property (p_sync) else $error("halt unsynced");
	a_grant: assert property (p_grant) else $error("no grant ack");
	a_mgmt: assert property (p_mgmt) else $error("no mgmt ack");
	a_float: assert property (p_float) else $error("not floated");
	a_pg: assert property (p_pg) else $error("no reset pulse");
endmodule : crs_link_chk

// >>> verification/tb_top.sv
// tb_top: both link ends joined, user sides driven and checked
// assumes 100 MHz clock and a shortened platform reset pulse
`timescale 1ns/1ps
module tb_top;
	logic clk = 0, reset = 1, stable = 0, mgmt_req = 0, halt_req = 0;
	logic mgmt_exit = 0, dreq = 0, preq = 0;
	logic [2:0] dcode = 3'h0, pcode = 3'h0;
	logic [7:0] cfg = 8'hA5, cfg_latched;
	logic mgmt_mode, grant_state, core_clk_en, cache_valid, state_saved;
	logic outputs_float, parity_error, sys_running;
	int err_count = 0, check_count = 0, cyc = 0;
	// expected {parity, status} for codes 0 to 7
	logic [3:0] rows [8] = '{4'hF, 4'h6, 4'h5, 4'hC, 4'h3, 4'hA, 4'h9, 4'h0};
	crs_link_if link();
	crs_device i_crs_device(.clk(clk), .link(link), .mgmt_mode(mgmt_mode),
		.grant_state(grant_state), .core_clk_en(core_clk_en),
		.cache_valid(cache_valid), .state_saved(state_saved),
		.outputs_float(outputs_float), .cfg_latched(cfg_latched),
		.parity_error(parity_error), .mgmt_exit(mgmt_exit),
		.resp_req(dreq), .resp_code(dcode));
	crs_platform #(.RESET_CYC(20)) i_crs_platform(.clk(clk), .reset(reset),
		.link(link), .supplies_stable(stable), .mgmt_req(mgmt_req),
		.halt_req(halt_req), .cfg_value(cfg), .resp_req(preq),
		.resp_code(pcode), .sys_running(sys_running));
	crs_link_chk i_crs_link_chk(.clk(clk), .reset(reset),
		.supply_ok_in(link.supply_ok_in), .reset_n(link.reset_n),
		.mgmt_interrupt_n(link.mgmt_interrupt_n),
		.clock_halt_req_n(link.clock_halt_req_n),
		.dev_req_cmd_n(link.dev_req_cmd_n), .dev_req_oe(link.dev_req_oe),
		.dev_addr_strobe_n(link.dev_addr_strobe_n),
		.dev_rs_oe(link.dev_rs_oe),
		.response_status_n(link.response_status_n),
		.response_parity_n(link.response_parity_n));
	logic [3:0] rsp_lines;
	assign rsp_lines = {link.response_parity_n, link.response_status_n};
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	initial forever #5 clk = ~clk;
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 6000)
		begin
			err_count++;
			wrap_up();
		end
	end
	task chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task chk_rsp(input logic [3:0] got, input logic [3:0] exp);
		check_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_rsp
	task chk_bit(input logic got, input logic exp);
		check_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_bit
	task automatic wait_on(ref logic s, input logic v);
		for (int k = 0; k < 80 && s !== v; k++)
		begin
			@(posedge clk);
			#1;
		end
	endtask : wait_on
	task wrap_up;
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up
	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial
	begin
		repeat (16) @(posedge clk);
		reset <= 0;
		stable <= 1;
		wait_on(sys_running, 1'b1);
		repeat (3) @(posedge clk);
		#1;
		chk(cfg_latched, 8'hA5);
		// device answers rows 0-7, platform rows 8-15
		for (int i = 0; i < 16; i++)
		begin
			@(posedge clk);
			dcode <= i[2:0];
			pcode <= i[2:0];
			dreq <= !i[3];
			preq <= i[3];
			if (i < 8)
				wait_on(link.dev_rs_oe, 1);
			else
				wait_on(link.plat_rs_oe, 1);
			chk_rsp(rsp_lines, rows[i % 8]);
			@(posedge clk);
			dreq <= 0;
			preq <= 0;
			#1;
			chk_bit(parity_error, 1'b0);
			repeat (4) @(posedge clk);
		end
		@(posedge clk);
		halt_req <= 1;
		wait_on(grant_state, 1'b1);
		chk_bit(core_clk_en, 1'b0);
		@(posedge clk);
		mgmt_req <= 1;
		wait_on(mgmt_mode, 1'b1);
		chk_bit(state_saved, 1'b1);
		@(posedge clk);
		mgmt_req <= 0;
		halt_req <= 0;
		repeat (6) @(posedge clk);
		mgmt_exit <= 1;
		@(posedge clk);
		mgmt_exit <= 0;
		#1;
		chk_bit(mgmt_mode, 1'b0);
		chk_bit(grant_state, 1'b0);
		chk_bit(state_saved, 1'b0);
		// halt and release straight from run
		@(posedge clk);
		halt_req <= 1;
		wait_on(grant_state, 1'b1);
		chk_bit(core_clk_en, 1'b0);
		@(posedge clk);
		halt_req <= 0;
		wait_on(grant_state, 1'b0);
		chk_bit(core_clk_en, 1'b1);
		// second reset with the interrupt held through release
		@(posedge clk);
		reset <= 1;
		cfg <= 8'h3C;
		mgmt_req <= 1;
		dreq <= 1;
		@(posedge clk);
		reset <= 0;
		repeat (6) @(posedge clk);
		#1;
		chk_bit(cache_valid, 1'b0);
		chk_bit(link.dev_req_oe, 1'b0);
		chk_bit(link.dev_rs_oe, 1'b0);
		wait_on(sys_running, 1'b1);
		wait_on(outputs_float, 1'b1);
		repeat (8) @(posedge clk);
		#1;
		chk_bit(outputs_float, 1'b1);
		chk_bit(link.dev_rs_oe, 1'b0);
		chk(cfg_latched, 8'h3C);
		wrap_up();
	end
endmodule : tb_top
